// ==== src/codec_ctrl_defs.vh ====
// constants for the codec control register bank
`ifndef CODEC_CTRL_DEFS_VH
`define CODEC_CTRL_DEFS_VH
// ==========================================
// control word fields
`define CW_DEV_HI 15
`define CW_DEV_LO 13
`define CW_RW_BIT 12
`define CW_REG_HI 11
`define CW_REG_LO 9
`define CW_DATA_HI 7
// ==========================================
// register addresses
`define REG_NOP 3'h0
`define REG_CTRL_ONE 3'h1
`define REG_CTRL_TWO 3'h2
`define REG_CTRL_THREE 3'h3
`define REG_GAIN 3'h4
// ==========================================
// reset values
`define CTRL_ONE_RST 8'h00
`define CTRL_TWO_RST 8'h00
`define CTRL_THREE_RST 8'h00
`define GAIN_RST 8'h00
`define STANDALONE_ADDR 3'h0
// ==========================================
// field positions
`define C1_OVF 7
`define C1_RX_AMP 6
`define C1_AAF_BYP 5
`define C1_AUX_SEL 4
`define C1_SW_RST 3
`define C1_FIR_BYP 2
`define C1_TX_AMP 1
`define C1_PLAY16 0
`define C2_LOW_PWR 7
`define C2_MOD_STOP 6
`define C2_RSVD 5
`define C3_FLAG_SRC 4
`define C3_FLAG_VAL 3
`define C3_CONT 5
`define C3_CAP16 0
// ==========================================
// test modes and power codes
`define TM_NORMAL 2'h0
`define TM_ALOOP 2'h1
`define TM_DLOOP 2'h2
`define TM_EVENT 2'h3
`define PD_NONE 2'h0
`define PD_CAP 2'h1
`define PD_PLAY 2'h2
`define PD_ALL 2'h3
`define DIV_ZERO_CODE 6'h20
`endif

// ==== src/sclk_divider.v ====
// shift-clock divider driven by the divide field
`timescale 1ns/1ps
module sclk_divider (
  input wire clk_i,
  input wire reset_n_i,
  input wire [5:0] divide_i,
  output reg tick_o,
  output reg half_o
);
  reg [5:0] cnt_reg;
  // ==========================================
  // counter: tick every divide_i cycles, half marks duty point
  // odd divisors give a low phase one cycle longer, so no 50% duty
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      cnt_reg <= 6'h00;
      tick_o <= 1'b0;
      half_o <= 1'b0;
    end else begin
      if (cnt_reg >= divide_i - 6'h01) begin
        cnt_reg <= 6'h00;
        tick_o <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 6'h01;
        tick_o <= 1'b0;
      end
      half_o <= (cnt_reg < {1'b0, divide_i[5:1]}); // R15
    end
  end
endmodule

// ==== src/codec_control_register_bank.v ====
// control register bank of a voice-band codec, fed by serial control words
// Operation
// (R1) cascade master address equals device count minus one
// (R2) act only when word device address matches
// (R3) standalone device answers device address zero
// (R4) bit twelve low writes, high reads
// (R5) low byte stored into addressed register
// (R6) bits eleven to nine select register
// (R7) control one bit seven reports overflow
// (R8) control one bit six enables receive amp
// (R9) aux input select and antialias bypass
// (R10) software reset bit is one-shot, self-clearing
// (R11) bit two bypasses decimation and interpolation
// (R12) bit one enables transmit amplifiers
// (R13) bit zero selects playback word format
// (R14) divider field, zero means thirty-two
// (R15) shift clock duty may be uneven
// (R16) control three test mode select
// (R17) continuous transfer only for cascade master; a standalone device also honours it
// (R18) flag pin source select
// (R19) capture sixteen-bit format select
// (R20) channel disable and software power-down codes
// (R21) modulator stop bit, bit five reads zero
// (R22) control two bit seven low power
// (R23) gain register holds two four-bit codes
`timescale 1ns/1ps
`include "codec_ctrl_defs.vh"
module codec_control_register_bank (
  input wire CLK_I,
  input wire RESET_N_I,
  input wire WORD_VALID_I,
  input wire [15:0] WORD_I,
  input wire [2:0] CASCADE_COUNT_I,
  input wire CASCADE_VALID_I,
  input wire OVERFLOW_I,
  input wire SEC_COMM_FLAG_I,
  output reg READ_VALID_O,
  output reg [15:0] READ_WORD_O,
  output reg SOFT_RESET_O,
  output reg RECEIVE_AMP_EN_O,
  output reg AAF_BYPASS_O,
  output reg AUX_INPUT_SEL_O,
  output reg FIR_BYPASS_O,
  output reg TRANSMIT_AMP_EN_O,
  output reg PLAY_16BIT_O,
  output reg LOW_POWER_O,
  output reg MOD_STOP_O,
  output reg [5:0] SCLK_DIVIDE_O,
  output reg SCLK_TICK_O,
  output reg SCLK_LEVEL_O,
  output reg [1:0] TEST_MODE_O,
  output reg EVENT_MONITOR_O,
  output reg CONTINUOUS_O,
  output reg FLAG_O,
  output reg CAPTURE_OFF_O,
  output reg PLAYBACK_OFF_O,
  output reg POWER_DOWN_O,
  output reg CAPTURE_16BIT_O,
  output reg [3:0] CAPTURE_GAIN_O,
  output reg [3:0] PLAY_GAIN_O,
  output reg CAPTURE_MUTE_O,
  output reg PLAY_MUTE_O
);
  // ==========================================
  // registers and pin synchronisers
  reg [7:0] ctrl_one_reg;
  reg [7:0] ctrl_two_reg;
  reg [7:0] ctrl_three_reg;
  reg [7:0] gain_reg;
  reg ovf_reg;
  reg [2:0] dev_addr_reg;
  reg [1:0] ovf_sync_reg;
  reg [1:0] flag_sync_reg;
  reg [1:0] casc_v_sync_reg;
  reg [2:0] casc_c_meta_reg;
  reg [2:0] casc_c_sync_reg;
  wire [2:0] word_dev;
  wire word_read;
  wire [2:0] word_reg;
  wire [7:0] word_data;
  wire hit;
  wire wr;
  wire rd;
  reg [7:0] rd_data;
  wire [5:0] div_eff;
  wire is_master;
  wire div_tick;
  wire div_half;

  assign word_dev = WORD_I[`CW_DEV_HI:`CW_DEV_LO]; // R2
  assign word_read = WORD_I[`CW_RW_BIT]; // R4
  assign word_reg = WORD_I[`CW_REG_HI:`CW_REG_LO]; // R6
  assign word_data = WORD_I[`CW_DATA_HI:0]; // R5
  // ==========================================
  // address match gates every access
  assign hit = WORD_VALID_I && (word_dev == dev_addr_reg); // R2
  assign wr = hit && !word_read; // R4
  assign rd = hit && word_read; // R4

  // ==========================================
  // two-stage sync of the level pins from outside the clock domain
  always @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      ovf_sync_reg <= 2'h0;
      flag_sync_reg <= 2'h0;
      casc_v_sync_reg <= 2'h0;
      casc_c_meta_reg <= 3'h0;
      casc_c_sync_reg <= 3'h0;
    end else begin
      ovf_sync_reg <= {ovf_sync_reg[0], OVERFLOW_I};
      flag_sync_reg <= {flag_sync_reg[0], SEC_COMM_FLAG_I};
      casc_v_sync_reg <= {casc_v_sync_reg[0], CASCADE_VALID_I};
      casc_c_meta_reg <= CASCADE_COUNT_I;
      casc_c_sync_reg <= casc_c_meta_reg;
    end
  end

  // ==========================================
  // device address from cascade detection
  // count input is the number of devices minus one at this position
  always @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      dev_addr_reg <= `STANDALONE_ADDR; // R3
    end else if (casc_v_sync_reg[1]) begin
      dev_addr_reg <= casc_c_sync_reg; // R1
    end else begin
      dev_addr_reg <= `STANDALONE_ADDR; // R3
    end
  end
  // master is any cascaded device whose address is not zero
  assign is_master = casc_v_sync_reg[1] && (dev_addr_reg != 3'h0); // R1

  // ==========================================
  // register writes; reset bit self-clears the cycle after the write
  always @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      ctrl_one_reg <= `CTRL_ONE_RST;
      ctrl_two_reg <= `CTRL_TWO_RST;
      ctrl_three_reg <= `CTRL_THREE_RST;
      gain_reg <= `GAIN_RST; // R23
    end else begin
      ctrl_one_reg[`C1_SW_RST] <= 1'b0; // R10
      if (wr) begin
        case (word_reg)
          `REG_CTRL_ONE: begin
            ctrl_one_reg <= word_data; // R5
          end
          `REG_CTRL_TWO: begin
            ctrl_two_reg <= word_data; // R5
          end
          `REG_CTRL_THREE: begin
            ctrl_three_reg <= word_data; // R5
          end
          `REG_GAIN: begin
            gain_reg <= word_data; // R23
          end
          default: begin
            ctrl_two_reg <= ctrl_two_reg; // R6
          end
        endcase
      end
    end
  end

  // ==========================================
  // sticky overflow flag; a new overflow wins over the read clear
  always @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      ovf_reg <= 1'b0;
    end else if (ovf_sync_reg[1]) begin
      ovf_reg <= 1'b1; // R7
    end else if (rd && word_reg == `REG_CTRL_ONE) begin
      ovf_reg <= 1'b0;
    end
  end

  // ==========================================
  // read data mux; status and reserved bits patched in
  always @* begin
    case (word_reg)
      `REG_CTRL_ONE: begin
        rd_data = {ovf_reg, ctrl_one_reg[6:4], 1'b0,
                   ctrl_one_reg[2:0]}; // R7
      end
      `REG_CTRL_TWO: begin
        rd_data = {ctrl_two_reg[7:6], 1'b0, ctrl_two_reg[4:0]}; // R21
      end
      `REG_CTRL_THREE: begin
        rd_data = ctrl_three_reg;
      end
      `REG_GAIN: begin
        rd_data = gain_reg;
      end
      default: begin
        rd_data = 8'h00; // R6
      end
    endcase
  end

  // ==========================================
  // read answer echoes the upper byte of the request
  always @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      READ_VALID_O <= 1'b0;
      READ_WORD_O <= 16'h0000;
    end else begin
      READ_VALID_O <= rd; // R4
      if (rd) begin
        READ_WORD_O <= {WORD_I[15:8], rd_data};
      end
    end
  end

  // ==========================================
  // divider field, zero code divides by thirty-two
  assign div_eff = (ctrl_two_reg[4:0] == 5'h00) ? `DIV_ZERO_CODE :
                   {1'b0, ctrl_two_reg[4:0]}; // R14

  sclk_divider u_div (
    .clk_i(CLK_I),
    .reset_n_i(RESET_N_I),
    .divide_i(div_eff),
    .tick_o(div_tick),
    .half_o(div_half)
  );

  // ==========================================
  // decoded control outputs, all registered
  always @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      SOFT_RESET_O <= 1'b0;
      RECEIVE_AMP_EN_O <= 1'b0;
      AAF_BYPASS_O <= 1'b0;
      AUX_INPUT_SEL_O <= 1'b0;
      FIR_BYPASS_O <= 1'b0;
      TRANSMIT_AMP_EN_O <= 1'b0;
      PLAY_16BIT_O <= 1'b0;
      LOW_POWER_O <= 1'b0;
      MOD_STOP_O <= 1'b0;
      SCLK_DIVIDE_O <= 6'h00;
      SCLK_TICK_O <= 1'b0;
      SCLK_LEVEL_O <= 1'b0;
      TEST_MODE_O <= `TM_NORMAL;
      EVENT_MONITOR_O <= 1'b0;
      CONTINUOUS_O <= 1'b0;
      FLAG_O <= 1'b0;
      CAPTURE_OFF_O <= 1'b0;
      PLAYBACK_OFF_O <= 1'b0;
      POWER_DOWN_O <= 1'b0;
      CAPTURE_16BIT_O <= 1'b0;
      CAPTURE_GAIN_O <= 4'h0;
      PLAY_GAIN_O <= 4'h0;
      CAPTURE_MUTE_O <= 1'b0;
      PLAY_MUTE_O <= 1'b0;
    end else begin
      SOFT_RESET_O <= ctrl_one_reg[`C1_SW_RST]; // R10
      RECEIVE_AMP_EN_O <= ctrl_one_reg[`C1_RX_AMP]; // R8
      AAF_BYPASS_O <= ctrl_one_reg[`C1_AAF_BYP]; // R9
      AUX_INPUT_SEL_O <= ctrl_one_reg[`C1_AUX_SEL]; // R9
      FIR_BYPASS_O <= ctrl_one_reg[`C1_FIR_BYP]; // R11
      TRANSMIT_AMP_EN_O <= ctrl_one_reg[`C1_TX_AMP]; // R12
      PLAY_16BIT_O <= ctrl_one_reg[`C1_PLAY16]; // R13
      LOW_POWER_O <= ctrl_two_reg[`C2_LOW_PWR]; // R22
      MOD_STOP_O <= ctrl_two_reg[`C2_MOD_STOP]; // R21
      SCLK_DIVIDE_O <= div_eff; // R14
      SCLK_TICK_O <= div_tick; // R15
      SCLK_LEVEL_O <= div_half; // R15
      TEST_MODE_O <= ctrl_three_reg[7:6]; // R16
      // event monitor only watches write cycles
      EVENT_MONITOR_O <= (ctrl_three_reg[7:6] == `TM_EVENT) && wr; // R16
      // ignored on slaves: only the master or a standalone device paces continuous frames
      CONTINUOUS_O <= ctrl_three_reg[`C3_CONT] &&
                      (is_master || !casc_v_sync_reg[1]); // R17
      FLAG_O <= ctrl_three_reg[`C3_FLAG_SRC] ?
                ctrl_three_reg[`C3_FLAG_VAL] : flag_sync_reg[1]; // R18
      CAPTURE_OFF_O <= (ctrl_three_reg[2:1] == `PD_CAP); // R20
      PLAYBACK_OFF_O <= (ctrl_three_reg[2:1] == `PD_PLAY); // R20
      POWER_DOWN_O <= (ctrl_three_reg[2:1] == `PD_ALL); // R20
      CAPTURE_16BIT_O <= ctrl_three_reg[`C3_CAP16]; // R19
      CAPTURE_GAIN_O <= gain_reg[7:4]; // R23
      PLAY_GAIN_O <= gain_reg[3:0]; // R23
      CAPTURE_MUTE_O <= (gain_reg[7:4] == 4'hF); // R23
      PLAY_MUTE_O <= (gain_reg[3:0] == 4'hF); // R23
    end
  end
endmodule

// ==== verification/codec_ctrl_props.sv ====
// assertion checker for the codec control register bank
`timescale 1ns/1ps
module codec_ctrl_checker (
  input wire CLK_I,
  input wire RESET_N_I,
  input wire WORD_VALID_I,
  input wire [15:0] WORD_I,
  input wire CASCADE_VALID_I,
  input wire READ_VALID_O,
  input wire [15:0] READ_WORD_O,
  input wire RECEIVE_AMP_EN_O,
  input wire SOFT_RESET_O,
  input wire [5:0] SCLK_DIVIDE_O,
  input wire EVENT_MONITOR_O,
  input wire CAPTURE_OFF_O,
  input wire PLAYBACK_OFF_O,
  input wire POWER_DOWN_O,
  input wire [3:0] CAPTURE_GAIN_O,
  input wire CAPTURE_MUTE_O
);
  // ==========================================
  // helpers
  // address syncs need three calm edges, so words before that are skipped
  reg [1:0] calm_reg;
  wire acc = WORD_VALID_I && calm_reg == 2'h3 && WORD_I[15:13] == 3'h0;
  wire rd = acc && WORD_I[12];
  wire wr1 = acc && !WORD_I[12] && WORD_I[11:9] == 3'h1;
  wire wr2 = acc && !WORD_I[12] && WORD_I[11:9] == 3'h2;
  always @(posedge CLK_I) begin
    if (!RESET_N_I || CASCADE_VALID_I) calm_reg <= 2'h0;
    else if (calm_reg != 2'h3) calm_reg <= calm_reg + 2'h1;
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  // ==========================================
  // properties
  a_read_echo: assert property (
    rd |=> READ_VALID_O && READ_WORD_O[15:8] == $past(WORD_I[15:8]))
    else $error("read answer missing or wrong header");
  a_nop_read: assert property (
    rd && WORD_I[11:9] == 3'h0 |=> READ_WORD_O[7:0] == 8'h00)
    else $error("no-op read gave data");
  a_rx_amp: assert property (
    wr1 ##1 !WORD_VALID_I ##1 !WORD_VALID_I
    |-> RECEIVE_AMP_EN_O == $past(WORD_I[6], 2))
    else $error("receive amp enable not written");
  a_soft_pulse: assert property (
    wr1 && WORD_I[3] |=> !SOFT_RESET_O ##1 SOFT_RESET_O ##1 !SOFT_RESET_O)
    else $error("soft reset not a single pulse");
  a_div_zero: assert property (
    wr2 && WORD_I[4:0] == 5'h00 ##1 !WORD_VALID_I ##1 !WORD_VALID_I
    |-> SCLK_DIVIDE_O == 6'h20)
    else $error("zero divider field not 32");
  a_power_code: assert property (
    $onehot0({CAPTURE_OFF_O, PLAYBACK_OFF_O, POWER_DOWN_O}))
    else $error("power codes overlap");
  a_mute_code: assert property (
    CAPTURE_MUTE_O == (CAPTURE_GAIN_O == 4'hF))
    else $error("capture mute disagrees with gain");
  a_event_write: assert property (
    EVENT_MONITOR_O |-> $past(WORD_VALID_I) || $past(WORD_VALID_I, 2))
    else $error("event pulse without write");
  c_read: cover property (READ_VALID_O);
  c_soft: cover property (SOFT_RESET_O);
  c_event: cover property (EVENT_MONITOR_O);
endmodule
bind codec_control_register_bank codec_ctrl_checker chk (.CLK_I, .RESET_N_I,
  .WORD_VALID_I, .WORD_I, .CASCADE_VALID_I, .READ_VALID_O, .READ_WORD_O,
  .RECEIVE_AMP_EN_O, .SOFT_RESET_O, .SCLK_DIVIDE_O, .EVENT_MONITOR_O,
  .CAPTURE_OFF_O, .PLAYBACK_OFF_O, .POWER_DOWN_O, .CAPTURE_GAIN_O,
  .CAPTURE_MUTE_O);

// ==== verification/host_model.sv ====
// host processor model issuing control words
`timescale 1ns/1ps
module host_model (
  input wire clk_i,
  output reg valid_o,
  output reg [15:0] word_o
);
  // ==========================================
  // word issue
  initial begin
    valid_o = 1'b0;
    word_o = 16'h0000;
  end
  // idle line shows the inverse so a stale word never looks valid
  task send(input [15:0] w);
    begin
      @(negedge clk_i);
      valid_o <= 1'b1;
      word_o <= w;
      @(negedge clk_i);
      valid_o <= 1'b0;
      word_o <= ~w;
    end
  endtask
endmodule

// ==== verification/tb_top.sv ====
// self-checking bench for the codec control register bank
`timescale 1ns/1ps
module tb_top;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg cas_vld = 1'b0;
  reg ovf = 1'b0;
  reg sec = 1'b0;
  reg b8 = 1'b0;
  reg [2:0] cas_cnt = 3'h0;
  wire vld, rv, srst, rx, aaf, aux, fir, tx, p16, lp, ms, tick, lvl;
  wire ev, cont, flag, coff, poff, pd, c16, cm, pm;
  wire [15:0] word, rw;
  wire [5:0] div;
  wire [1:0] tm;
  wire [3:0] cg, pg;
  reg [7:0] sh [0:7];
  reg [15:0] q [$];
  reg [15:0] e;
  reg [7:0] d;
  integer bad_count = 0, checked = 0, cycles = 0, i, r, k, h;
  // ==========================================
  // clock, host and device
  always #5 clk = ~clk;
  host_model host (.clk_i(clk), .valid_o(vld), .word_o(word));
  codec_control_register_bank DUT (.CLK_I(clk), .RESET_N_I(rst_n),
    .WORD_VALID_I(vld), .WORD_I(word), .CASCADE_COUNT_I(cas_cnt),
    .CASCADE_VALID_I(cas_vld), .OVERFLOW_I(ovf), .SEC_COMM_FLAG_I(sec),
    .READ_VALID_O(rv), .READ_WORD_O(rw), .SOFT_RESET_O(srst),
    .RECEIVE_AMP_EN_O(rx), .AAF_BYPASS_O(aaf), .AUX_INPUT_SEL_O(aux),
    .FIR_BYPASS_O(fir), .TRANSMIT_AMP_EN_O(tx), .PLAY_16BIT_O(p16),
    .LOW_POWER_O(lp), .MOD_STOP_O(ms), .SCLK_DIVIDE_O(div),
    .SCLK_TICK_O(tick), .SCLK_LEVEL_O(lvl), .TEST_MODE_O(tm),
    .EVENT_MONITOR_O(ev), .CONTINUOUS_O(cont), .FLAG_O(flag),
    .CAPTURE_OFF_O(coff), .PLAYBACK_OFF_O(poff), .POWER_DOWN_O(pd),
    .CAPTURE_16BIT_O(c16), .CAPTURE_GAIN_O(cg), .PLAY_GAIN_O(pg),
    .CAPTURE_MUTE_O(cm), .PLAY_MUTE_O(pm));
  // ==========================================
  // checking tasks
  task stop_test;
    begin
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input [15:0] exp, input [15:0] got, input [8*10-1:0] what);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("MISMATCH %0s exp %h got %h", what, exp, got);
      end
    end
  endtask
  // overflow, soft reset and control two bit five never read back as stored
  function [7:0] keep(input [2:0] a, input [7:0] v);
    keep = a == 3'h1 ? v & 8'h77 : a == 3'h2 ? v & 8'hDF : v;
  endfunction
  task wr(input [2:0] dev, input [2:0] a, input [7:0] v);
    begin
      b8 = $urandom;
      host.send({dev, 1'b0, a, b8, v});
      sh[a] = keep(a, v);
      repeat (3) @(negedge clk);
    end
  endtask
  task rd(input [2:0] dev, input [2:0] a, input [7:0] x);
    begin
      b8 = $urandom;
      q.push_back({dev, 1'b1, a, b8, sh[a] | x});
      host.send({dev, 1'b1, a, b8, 8'h00});
    end
  endtask
  // shift clock: period of n cycles, level high for the shorter half
  task sclk_chk(input [5:0] n);
    begin
      wr(3'h0, 3'h2, {3'h0, n[4:0]});
      // wait for two ticks so the period measured is all at the new divider
      repeat (2) begin
        @(negedge clk);
        while (tick !== 1'b1) @(negedge clk);
      end
      k = 0;
      h = 0;
      do begin
        @(negedge clk);
        k = k + 1;
        h = h + lvl;
      end while (tick !== 1'b1);
      chk({10'h000, n}, k[15:0], "sclk per");
      chk({11'h000, n[5:1]}, h[15:0], "sclk high");
    end
  endtask
  task outs;
    begin
      chk({sh[1][6:4], sh[1][2:0]},
        {rx, aaf, aux, fir, tx, p16}, "ctrl1");
      d = sh[2][4:0] == 5'h00 ? 8'h20 : {3'h0, sh[2][4:0]};
      chk({sh[2][7:6], d[5:0]}, {lp, ms, div}, "ctrl2");
      d = sh[3];
      chk({d[7:5], d[4] ? d[3] : sec, d[2:1] == 2'h1,
        d[2:1] == 2'h2, d[2:1] == 2'h3, d[0]},
        {tm, cont, flag, coff, poff, pd, c16}, "ctrl3");
      chk({sh[4], sh[4][7:4] == 4'hF, sh[4][3:0] == 4'hF},
        {cg, pg, cm, pm}, "gain");
    end
  endtask
  // ==========================================
  // read answers matched in issue order; hang guard
  // sampled mid-cycle, away from the edge that launches the answer
  always @(negedge clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      bad_count = bad_count + 1;
      stop_test;
    end
    if (rst_n && rv === 1'b1) begin
      if (q.size() == 0) chk(16'h0000, 16'h0001, "stray");
      else begin
        e = q.pop_front();
        chk(e, rw, "read word");
      end
    end
  end
  // ==========================================
  // main sequence
  initial begin
    d = $urandom(32'hD7CC7D81);
    for (i = 0; i < 8; i = i + 1) sh[i] = 8'h00;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    for (r = 0; r < 8; r = r + 1) rd(3'h0, r[2:0], 8'h00);
    wr(3'h0, 3'h1, 8'h08);
    rd(3'h0, 3'h1, 8'h00);
    // words for another device are ignored
    host.send({3'h5, 1'b0, 3'h3, 9'h0FF});
    host.send({3'h2, 1'b1, 3'h3, 9'h000});
    rd(3'h0, 3'h3, 8'h00);
    // all-zero and all-one settings first, then random ones
    for (i = 0; i < 12; i = i + 1) begin
      sec = $urandom;
      for (r = 1; r < 5; r = r + 1) begin
        d = i == 0 ? 8'h00 : i == 1 ? 8'hFF : $urandom;
        wr(3'h0, r[2:0], r == 1 ? d & 8'hF7 : d);
        rd(3'h0, r[2:0], 8'h00);
      end
      outs;
    end
    // sticky overflow, cleared by the read that reports it
    ovf = 1'b1;
    repeat (4) @(negedge clk);
    ovf = 1'b0;
    repeat (4) @(negedge clk);
    rd(3'h0, 3'h1, 8'h80);
    rd(3'h0, 3'h1, 8'h00);
    // divider end points first, then a random one
    for (i = 0; i < 3; i = i + 1) begin
      sclk_chk(i == 0 ? 6'h20 : i == 1 ? 6'h01 : 6'h01 + $urandom % 31);
    end
    // cascade master at address three answers only there
    cas_cnt = 3'h3;
    cas_vld = 1'b1;
    repeat (4) @(negedge clk);
    host.send({3'h0, 1'b1, 3'h3, 9'h000});
    wr(3'h3, 3'h3, 8'h20);
    rd(3'h3, 3'h3, 8'h00);
    chk(16'h0001, {15'h0000, cont}, "continuous");
    cas_vld = 1'b0;
    repeat (6) @(negedge clk);
    // every read issued must have been answered
    chk(16'h0000, q.size(), "pending");
    stop_test;
  end
endmodule
